// ==== aos_pkg.sv ====
// Shared constants, types and decode functions for the adder operand selector
`default_nettype none
package aos_pkg;

	// ------------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------------
	localparam int unsigned AOS_WORD_W = 16;
	localparam int unsigned AOS_BYTE_W = 8;
	localparam int unsigned AOS_AMP_W  = 14;
	localparam int unsigned AOS_ADDR_W = 8;

	// ------------------------------------------------------------------
	// Positions of nanobits N20..N26 inside the y field, N28..N31 in op field
	// ------------------------------------------------------------------
	localparam int unsigned AOS_NB_MSB0 = 0; // N20
	localparam int unsigned AOS_NB_MSB1 = 1; // N21
	localparam int unsigned AOS_NB_SRC2 = 2; // N22, heaviest source bit
	localparam int unsigned AOS_NB_SRC1 = 3; // N23
	localparam int unsigned AOS_NB_SRC0 = 4; // N24
	localparam int unsigned AOS_NB_LSB0 = 5; // N25
	localparam int unsigned AOS_NB_LSB1 = 6; // N26

	// ------------------------------------------------------------------
	// Y source codes on N22..N24 and the source select encoding
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		AOS_YC_ZERO = 3'h0,
		AOS_YC_LTRL = 3'h1,
		AOS_YC_NONE = 3'h2,
		AOS_YC_CNTR = 3'h3,
		AOS_YC_B    = 3'h4,
		AOS_YC_ZCL  = 3'h5,
		AOS_YC_AMP  = 3'h6,
		AOS_YC_BASE = 3'h7
	} aos_ycode_t;

	typedef enum logic [1:0] {
		AOS_YS_B    = 2'h0,
		AOS_YS_AMP  = 2'h1,
		AOS_YS_ZCL  = 2'h2,
		AOS_YS_BASE = 2'h3
	} aos_ysrc_t;

	typedef enum logic [1:0] {
		AOS_XS_ACC1 = 2'h0,
		AOS_XS_ACC2 = 2'h1,
		AOS_XS_ACC3 = 2'h2,
		AOS_XS_ZCL  = 2'h3
	} aos_xsrc_t;

	// ------------------------------------------------------------------
	// Register map and reset values
	// ------------------------------------------------------------------
	localparam logic [7:0]  AOS_OFS_CTRL   = 8'h00;
	localparam logic [7:0]  AOS_OFS_YCTL   = 8'h04;
	localparam logic [7:0]  AOS_OFS_YOPND  = 8'h08;
	localparam logic [7:0]  AOS_OFS_XOPND  = 8'h0c;
	localparam logic [7:0]  AOS_OFS_ALUCTL = 8'h10;
	localparam int unsigned AOS_CTRL_BASE_BIT = 0;
	localparam logic [3:0]  AOS_OP_RST     = 4'h0;
	localparam logic [31:0] AOS_RD_ZERO    = 32'h0000_0000;

	// Edge bit select: 00 zero, 01 true, 10 complement, 11 one
	function automatic logic aos_edge_bit(input logic c0, input logic c1, input logic src);
		case ({c0, c1})
			2'h0:    aos_edge_bit = 1'b0;
			2'h1:    aos_edge_bit = src;
			2'h2:    aos_edge_bit = ~src;
			default: aos_edge_bit = 1'b1;
		endcase
	endfunction : aos_edge_bit

	// Operation code to {mode flag, function selects 3..0}
	function automatic logic [4:0] aos_op_decode(input logic [3:0] op);
		case (op)
			4'h0:    aos_op_decode = 5'h19;
			4'h1:    aos_op_decode = 5'h01;
			4'h2:    aos_op_decode = 5'h02;
			4'h3:    aos_op_decode = 5'h19;
			4'h4:    aos_op_decode = 5'h04;
			4'h5:    aos_op_decode = 5'h1d;
			4'h6:    aos_op_decode = 5'h06;
			4'h7:    aos_op_decode = 5'h07;
			4'h8:    aos_op_decode = 5'h08;
			4'h9:    aos_op_decode = 5'h09;
			4'ha:    aos_op_decode = 5'h1c;
			4'hb:    aos_op_decode = 5'h0b;
			4'hc:    aos_op_decode = 5'h16;
			4'hd:    aos_op_decode = 5'h0d;
			4'he:    aos_op_decode = 5'h0e;
			default: aos_op_decode = 5'h16;
		endcase
	endfunction : aos_op_decode

endpackage : aos_pkg
`default_nettype wire

// ==== aos_ysel.sv ====
// Y-side operand selector: source choice, byte gating and edge bit control
`timescale 1ns/1ps
`default_nettype none
module aos_ysel
	import aos_pkg::*;
#(
	parameter int unsigned WORD_W = AOS_WORD_W,
	parameter int unsigned AMP_W  = AOS_AMP_W
)(
	input  wire logic [1:0]        ysrc_sel,
	input  wire logic              high_byte_gate,
	input  wire logic              low_byte_gate,
	input  wire logic              msb_ctl_0,
	input  wire logic              msb_ctl_1,
	input  wire logic              lsb_ctl_0,
	input  wire logic              lsb_ctl_1,
	input  wire logic              base_sel,
	input  wire logic [WORD_W-1:0] b_reg,
	input  wire logic [7:0]        count_reg,
	input  wire logic [7:0]        literal_reg,
	input  wire logic [AMP_W-1:0]  alt_uprog_counter,
	input  wire logic [WORD_W-1:0] base_reg_one,
	input  wire logic [WORD_W-1:0] base_reg_two,
	input  wire logic [WORD_W-1:0] mem_addr_reg,
	output logic      [WORD_W-1:0] y_sel
);

	logic [WORD_W-1:0] raw;
	logic [WORD_W-1:0] base;

	// Source mux; b_reg is only read, so masking never touches the stored B
	always_comb
	begin
		base = base_sel ? base_reg_two : base_reg_one;
		case (aos_ysrc_t'(ysrc_sel))
			AOS_YS_B:    raw = b_reg;
			AOS_YS_ZCL:  raw = {count_reg, literal_reg};
			AOS_YS_AMP:  raw = {{(WORD_W-AMP_W){1'b0}}, alt_uprog_counter};
			AOS_YS_BASE: raw = WORD_W'(base + mem_addr_reg);
			default:     raw = '0;
		endcase
	end

	// Central bits are only zero or true; gates blank bits 14..8 and 7..1
	always_comb
	begin
		y_sel = raw;
		if (high_byte_gate)
		begin
			y_sel[WORD_W-2:WORD_W/2] = '0;
		end
		if (low_byte_gate)
		begin
			y_sel[WORD_W/2-1:1] = '0;
		end
		y_sel[WORD_W-1] = aos_edge_bit(msb_ctl_0, msb_ctl_1, raw[WORD_W-1]);
		y_sel[0]        = aos_edge_bit(lsb_ctl_0, lsb_ctl_1, raw[0]);
	end

endmodule : aos_ysel
`default_nettype wire

// ==== aos_xsel.sv ====
// X-side operand selector: plain register choice with no masking
`timescale 1ns/1ps
`default_nettype none
module aos_xsel
	import aos_pkg::*;
#(
	parameter int unsigned WORD_W = AOS_WORD_W
)(
	input  wire logic [1:0]        x_sel,
	input  wire logic [WORD_W-1:0] acc_reg_one,
	input  wire logic [WORD_W-1:0] acc_reg_two,
	input  wire logic [WORD_W-1:0] acc_reg_three,
	input  wire logic [7:0]        count_reg,
	input  wire logic [7:0]        literal_reg,
	output logic      [WORD_W-1:0] x_out
);

	// Pure selector, every bit passes unchanged
	always_comb
	begin
		case (aos_xsrc_t'(x_sel))
			AOS_XS_ACC1: x_out = acc_reg_one;
			AOS_XS_ACC2: x_out = acc_reg_two;
			AOS_XS_ACC3: x_out = acc_reg_three;
			AOS_XS_ZCL:  x_out = {count_reg, literal_reg};
			default:    x_out = '0;
		endcase
	end

endmodule : aos_xsel
`default_nettype wire

// ==== aos_operand_select.sv ====
// Adder operand selector top: microinstruction control register, operands, register port
// Overview of operation
// - Y picks zero, B, literal, counter, pair, alternate, base
// - Both byte gates zero Y bits 1..14
// - High gate governs counter onto high byte
// - Low gate governs literal onto low byte
// - Select lines choose B, pair, alternate, base
// - MSB code 00 zero, 01 true B
// - LSB codes: zero, true, complement, one
// - Source 000 gives zero, 100 gives B
// - Patterns route literal low, counter high
// - Patterns route pair, alternate count, base plus address
// - N22..24 decoded; edge nanobits registered directly
// - Masking never changes stored B contents
// - X picks an accumulator or pair, unmasked
// - Y operand is a 16-bit bus
// - Mode flag high arithmetic, low logical
// - Four function selects plus mode choose operation
// - N28..31 decode to mode and function selects
// - Central B bits only zero or true
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module aos_operand_select
	import aos_pkg::*;
#(
	parameter int unsigned WORD_W = AOS_WORD_W,
	parameter int unsigned AMP_W  = AOS_AMP_W
)(
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	input  wire logic                  clk_en,
	input  wire logic                  uinstr_load,
	input  wire logic [6:0]            nano_y,
	input  wire logic [3:0]            nano_alu,
	input  wire logic [1:0]            nano_x,
	input  wire logic [WORD_W-1:0]     b_reg,
	input  wire logic [7:0]            count_reg,
	input  wire logic [7:0]            literal_reg,
	input  wire logic [AMP_W-1:0]      alt_uprog_counter,
	input  wire logic [WORD_W-1:0]     base_reg_one,
	input  wire logic [WORD_W-1:0]     base_reg_two,
	input  wire logic [WORD_W-1:0]     mem_addr_reg,
	input  wire logic [WORD_W-1:0]     acc_reg_one,
	input  wire logic [WORD_W-1:0]     acc_reg_two,
	input  wire logic [WORD_W-1:0]     acc_reg_three,
	input  wire logic [AOS_ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [31:0]           reg_rdata,
	output logic      [WORD_W-1:0]     y_operand_bus,
	output logic      [WORD_W-1:0]     x_operand_bus,
	output logic                       arith_mode_flag,
	output logic                       alu_fn_sel_0,
	output logic                       alu_fn_sel_1,
	output logic                       alu_fn_sel_2,
	output logic                       alu_fn_sel_3,
	output logic                       alu_carry_in
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic              high_byte_gate;
		logic              low_byte_gate;
		logic              ysrc_sel_a;
		logic              ysrc_sel_b;
		logic              msb_ctl_0;
		logic              msb_ctl_1;
		logic              lsb_ctl_0;
		logic              lsb_ctl_1;
		logic [1:0]        x_sel;
		logic [3:0]        alu_op;
		logic              base_sel;
		logic [WORD_W-1:0] y_opnd;
		logic [WORD_W-1:0] x_opnd;
		logic [31:0]       rdata;
	} aos_state_t;

	aos_state_t        st;
	aos_state_t        next_st;
	logic              rst_meta_n;
	logic              rst_sync_n;
	logic [WORD_W-1:0] y_sel;
	logic [WORD_W-1:0] x_out;
	logic [4:0]        op_dec;
	logic [2:0]        ycode;

	// ------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------

	// Two-stage release so all state leaves reset on the same edge
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end
		else
		begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	// ------------------------------------------------------------------
	// Operand selectors
	// ------------------------------------------------------------------

	// Y side: the whole selection path lives in the leaf
	aos_ysel #(
		.WORD_W (WORD_W),
		.AMP_W  (AMP_W)
	) u_ysel (
		.ysrc_sel          ({st.ysrc_sel_a, st.ysrc_sel_b}),
		.high_byte_gate    (st.high_byte_gate),
		.low_byte_gate     (st.low_byte_gate),
		.msb_ctl_0         (st.msb_ctl_0),
		.msb_ctl_1         (st.msb_ctl_1),
		.lsb_ctl_0         (st.lsb_ctl_0),
		.lsb_ctl_1         (st.lsb_ctl_1),
		.base_sel          (st.base_sel),
		.b_reg             (b_reg),
		.count_reg         (count_reg),
		.literal_reg       (literal_reg),
		.alt_uprog_counter (alt_uprog_counter),
		.base_reg_one      (base_reg_one),
		.base_reg_two      (base_reg_two),
		.mem_addr_reg      (mem_addr_reg),
		.y_sel             (y_sel)
	);

	// X side: pure register choice
	aos_xsel #(
		.WORD_W (WORD_W)
	) u_xsel (
		.x_sel         (st.x_sel),
		.acc_reg_one   (acc_reg_one),
		.acc_reg_two   (acc_reg_two),
		.acc_reg_three (acc_reg_three),
		.count_reg     (count_reg),
		.literal_reg   (literal_reg),
		.x_out         (x_out)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------

	// N22 is the heavy bit of the source code
	assign ycode = {nano_y[AOS_NB_SRC2], nano_y[AOS_NB_SRC1], nano_y[AOS_NB_SRC0]};

	// Control register load, operand staging and register port
	always_comb
	begin
		next_st = st;
		if (uinstr_load)
		begin
			// Every control flop loads on the same edge, so no mixed selection
			next_st.msb_ctl_0 = nano_y[AOS_NB_MSB0];
			next_st.msb_ctl_1 = nano_y[AOS_NB_MSB1];
			next_st.lsb_ctl_0 = nano_y[AOS_NB_LSB0];
			next_st.lsb_ctl_1 = nano_y[AOS_NB_LSB1];
			next_st.x_sel     = nano_x;
			next_st.alu_op    = nano_alu;
			case (aos_ycode_t'(ycode))
				AOS_YC_LTRL:
				begin
					// Counter half blanked, literal passes low byte
					next_st.high_byte_gate = 1'b1;
					next_st.low_byte_gate  = 1'b0;
					{next_st.ysrc_sel_a, next_st.ysrc_sel_b} = AOS_YS_ZCL;
				end
				AOS_YC_CNTR:
				begin
					next_st.high_byte_gate = 1'b0;
					next_st.low_byte_gate  = 1'b1;
					{next_st.ysrc_sel_a, next_st.ysrc_sel_b} = AOS_YS_ZCL;
				end
				AOS_YC_B:
				begin
					next_st.high_byte_gate = 1'b0;
					next_st.low_byte_gate  = 1'b0;
					{next_st.ysrc_sel_a, next_st.ysrc_sel_b} = AOS_YS_B;
				end
				AOS_YC_ZCL:
				begin
					next_st.high_byte_gate = 1'b0;
					next_st.low_byte_gate  = 1'b0;
					{next_st.ysrc_sel_a, next_st.ysrc_sel_b} = AOS_YS_ZCL;
				end
				AOS_YC_AMP:
				begin
					next_st.high_byte_gate = 1'b0;
					next_st.low_byte_gate  = 1'b0;
					{next_st.ysrc_sel_a, next_st.ysrc_sel_b} = AOS_YS_AMP;
				end
				AOS_YC_BASE:
				begin
					next_st.high_byte_gate = 1'b0;
					next_st.low_byte_gate  = 1'b0;
					{next_st.ysrc_sel_a, next_st.ysrc_sel_b} = AOS_YS_BASE;
				end
				default:
				begin
					// Zero and the unused code both blank the central bits
					next_st.high_byte_gate = 1'b1;
					next_st.low_byte_gate  = 1'b1;
					{next_st.ysrc_sel_a, next_st.ysrc_sel_b} = AOS_YS_B;
				end
			endcase
		end
		// Operands restaged every cycle from the live sources
		next_st.y_opnd = y_sel;
		next_st.x_opnd = x_out;
		if (reg_wr && reg_addr == AOS_OFS_CTRL)
		begin
			next_st.base_sel = reg_wdata[AOS_CTRL_BASE_BIT];
		end
		// Read data stands only in the cycle after the strobe
		next_st.rdata = AOS_RD_ZERO;
		if (reg_rd)
		begin
			case (reg_addr)
				AOS_OFS_CTRL:
					next_st.rdata = {31'h0000_0000, st.base_sel};
				AOS_OFS_YCTL:
					next_st.rdata = {20'h0_0000, st.x_sel, st.high_byte_gate,
						st.low_byte_gate, st.ysrc_sel_a, st.ysrc_sel_b, st.msb_ctl_0,
						st.msb_ctl_1, st.lsb_ctl_0, st.lsb_ctl_1, 2'h0};
				AOS_OFS_YOPND:
					next_st.rdata = {{(32-WORD_W){1'b0}}, st.y_opnd};
				AOS_OFS_XOPND:
					next_st.rdata = {{(32-WORD_W){1'b0}}, st.x_opnd};
				AOS_OFS_ALUCTL:
					next_st.rdata = {23'h00_0000, op_dec, st.alu_op};
				default:
					next_st.rdata = AOS_RD_ZERO;
			endcase
		end
	end

	// State register; clock enable low freezes everything
	always_ff @(posedge sys_clk or negedge rst_sync_n)
	begin
		if (!rst_sync_n)
		begin
			st <= '0;
		end
		else if (clk_en)
		begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------

	// Mode and function selects decoded from the held operation code
	assign op_dec          = aos_op_decode(st.alu_op);
	assign arith_mode_flag = op_dec[4];
	assign alu_fn_sel_3    = op_dec[3];
	assign alu_fn_sel_2    = op_dec[2];
	assign alu_fn_sel_1    = op_dec[1];
	assign alu_fn_sel_0    = op_dec[0];
	// Carry in only for add-plus-one and subtract
	assign alu_carry_in    = (st.alu_op == 4'h3) || (st.alu_op == 4'hf);
	// b_reg is an input only; nothing here can write it back
	assign y_operand_bus   = st.y_opnd;
	assign x_operand_bus   = st.x_opnd;
	assign reg_rdata       = st.rdata;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking aos_cb @(posedge sys_clk); endclocking
	default disable iff (!rst_sync_n);

	zero_gate_a: assert property (clk_en && st.high_byte_gate && st.low_byte_gate
		|=> y_operand_bus[WORD_W-2:1] == '0)
		else $error("central Y bits not zero under both gates");
	high_gate_a: assert property (clk_en && st.high_byte_gate
		|=> y_operand_bus[WORD_W-2:WORD_W/2] == '0)
		else $error("high byte passed while gated");
	low_gate_a: assert property (clk_en && st.low_byte_gate
		|=> y_operand_bus[WORD_W/2-1:1] == '0)
		else $error("low byte passed while gated");
	b_pass_a: assert property (clk_en && !st.high_byte_gate && !st.low_byte_gate
		&& {st.ysrc_sel_a, st.ysrc_sel_b} == 2'h0
		|=> y_operand_bus[WORD_W-2:1] == $past(b_reg[WORD_W-2:1]))
		else $error("B central bits not passed");
	msb_zero_a: assert property (clk_en && {st.msb_ctl_0, st.msb_ctl_1} == 2'h0
		|=> !y_operand_bus[WORD_W-1])
		else $error("MSB not zero for code 00");
	msb_cpl_a: assert property (clk_en && {st.msb_ctl_0, st.msb_ctl_1} == 2'h2
		&& {st.ysrc_sel_a, st.ysrc_sel_b} == 2'h0
		|=> y_operand_bus[WORD_W-1] == !$past(b_reg[WORD_W-1]))
		else $error("MSB not complemented for code 10");
	lsb_one_a: assert property (clk_en && {st.lsb_ctl_0, st.lsb_ctl_1} == 2'h3
		|=> y_operand_bus[0])
		else $error("LSB not one for code 11");
	ctl_load_a: assert property (clk_en && uinstr_load
		|=> st.msb_ctl_0 == $past(nano_y[0]) && st.lsb_ctl_1 == $past(nano_y[6])
		&& st.alu_op == $past(nano_alu))
		else $error("controls not loaded together");
	lit_decode_a: assert property (clk_en && uinstr_load && ycode == 3'h1
		|=> st.high_byte_gate && !st.low_byte_gate && st.ysrc_sel_a && !st.ysrc_sel_b)
		else $error("literal code decoded wrongly");
	sub_mode_a: assert property (clk_en && uinstr_load && nano_alu == 4'hf
		|=> arith_mode_flag && {alu_fn_sel_3, alu_fn_sel_2, alu_fn_sel_1, alu_fn_sel_0} == 4'h6)
		else $error("subtract not decoded");
	x_pass_a: assert property (clk_en && st.x_sel == 2'h0
		|=> x_operand_bus == $past(acc_reg_one))
		else $error("X selector masked the first accumulator");
	freeze_a: assert property (!clk_en |=> $stable(y_operand_bus) && $stable(reg_rdata))
		else $error("state moved while clock enable low");
	ctr_decode_a: assert property (clk_en && uinstr_load && ycode == 3'h3
		|=> !st.high_byte_gate && st.low_byte_gate && st.ysrc_sel_a && !st.ysrc_sel_b)
		else $error("counter code decoded wrongly");
	zero_decode_a: assert property (clk_en && uinstr_load && ycode == 3'h0
		|=> st.high_byte_gate && st.low_byte_gate && !st.ysrc_sel_a && !st.ysrc_sel_b)
		else $error("zero code decoded wrongly");
	alt_count_a: assert property (clk_en && {st.ysrc_sel_a, st.ysrc_sel_b} == 2'h1
		|=> y_operand_bus[WORD_W-2:1]
		== {{(WORD_W-1-AMP_W){1'b0}}, $past(alt_uprog_counter[AMP_W-1:1])})
		else $error("alternate count not zero extended");
	add_mode_a: assert property (clk_en && uinstr_load && nano_alu == 4'h0
		|=> arith_mode_flag && {alu_fn_sel_3, alu_fn_sel_2, alu_fn_sel_1, alu_fn_sel_0} == 4'h9)
		else $error("add not decoded");

	// Main scenarios worth seeing in a run, including a frozen stretch
	freeze_c: cover property (!clk_en ##1 !clk_en);
	lit_route_c: cover property (clk_en && uinstr_load && ycode == 3'h1 ##1 clk_en [*2]);
	ctr_route_c: cover property (clk_en && uinstr_load && ycode == 3'h3 ##1 clk_en [*2]);
	base_route_c: cover property (clk_en && uinstr_load && ycode == 3'h7 ##1 clk_en [*2]);
	reg_read_c: cover property (clk_en && reg_rd && reg_addr == AOS_OFS_YOPND);

endmodule : aos_operand_select
`default_nettype wire

// ==== aos_ucode_model.sv ====
// Model of the microcode control register that hands nanobit words to the selector
`timescale 1ns/1ps
`default_nettype none
module aos_ucode_model (
	input  wire logic       sys_clk,
	input  wire logic       issue,
	input  wire logic [6:0] word_y,
	input  wire logic [3:0] word_alu,
	input  wire logic [1:0] word_x,
	output logic      [6:0] nano_y = 7'h00,
	output logic      [3:0] nano_alu = 4'h0,
	output logic      [1:0] nano_x = 2'h0,
	output logic            uinstr_load = 1'b0
);
	// ----------------------------------------------------------------
	// Word issue
	// ----------------------------------------------------------------
	// Each word names one X and one Y operand; between words the fields
	// toggle, so a selector that loads at the wrong time sees garbage
	always @(posedge sys_clk)
	begin
		uinstr_load <= issue;
		nano_y      <= issue ? word_y : ~nano_y;
		nano_alu    <= issue ? word_alu : ~nano_alu;
		nano_x      <= issue ? word_x : ~nano_x;
	end
endmodule : aos_ucode_model
`default_nettype wire

// ==== test_adder_operand_select.sv ====
// Self-checking bench for the adder operand selector
`timescale 1ns/1ps
`default_nettype none
module test_adder_operand_select
	import aos_pkg::*;
;
	logic        sys_clk, rst_n, issue, reg_wr, reg_rd, bsel, ld, mode, f0, f1, f2, f3, cin, en;
	logic        ld1 = 1'b0, ld2 = 1'b0, rd1 = 1'b0;
	logic [6:0]  wy, ny;
	logic [3:0]  wa, na;
	logic [1:0]  wx, nx;
	logic [13:0] amp;
	logic [7:0]  cnt, ltrl, addr;
	logic [15:0] b, acc1, acc2, acc3, bas1, bas2, madr, y, x, ey, ex;
	logic [31:0] wdata, rdata;
	logic [5:0]  ea;
	logic [31:0] oq[$], rq[$];
	logic [5:0]  aq[$];
	logic [3:0]  gt[8] = '{4'hc, 4'ha, 4'hc, 4'h6, 4'h0, 4'h2, 4'h1, 4'h3};
	logic [4:0]  ot[16] = '{5'h19, 5'h01, 5'h02, 5'h19, 5'h04, 5'h1d, 5'h06, 5'h07,
		5'h08, 5'h09, 5'h1c, 5'h0b, 5'h16, 5'h0d, 5'h0e, 5'h16};
	int          n_mismatch = 0, n_compared = 0, seed = 10973, cyc = 0;

	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	aos_operand_select dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(en), .uinstr_load(ld),
		.nano_y(ny), .nano_alu(na), .nano_x(nx), .b_reg(b), .count_reg(cnt),
		.literal_reg(ltrl), .alt_uprog_counter(amp), .base_reg_one(bas1),
		.base_reg_two(bas2), .mem_addr_reg(madr), .acc_reg_one(acc1), .acc_reg_two(acc2),
		.acc_reg_three(acc3), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(rdata), .y_operand_bus(y), .x_operand_bus(x),
		.arith_mode_flag(mode), .alu_fn_sel_0(f0), .alu_fn_sel_1(f1),
		.alu_fn_sel_2(f2), .alu_fn_sel_3(f3), .alu_carry_in(cin)
	);

	aos_ucode_model u_ucode (
		.sys_clk(sys_clk), .issue(issue), .word_y(wy), .word_alu(wa), .word_x(wx),
		.nano_y(ny), .nano_alu(na), .nano_x(nx), .uinstr_load(ld)
	);

	// ----------------------------------------------------------------
	// Expectations and checks
	// ----------------------------------------------------------------
	// Edge bit: {c0,c1} 00 zero, 01 true, 10 complement, 11 one
	function automatic logic edge_f(input logic [1:0] c, input logic s);
		return c[1] ? (c[0] | ~s) : (c[0] & s);
	endfunction : edge_f

	// Gates only blank central bits, so the edge bits still follow their codes
	function automatic logic [15:0] exp_y(input logic [6:0] n);
		logic [2:0]  c;
		logic [15:0] s;
		c = {n[2], n[3], n[4]};
		case (c)
			3'h0, 3'h2, 3'h4: s = b;
			3'h6:             s = {2'h0, amp};
			3'h7:             s = (bsel ? bas2 : bas1) + madr;
			default:          s = {cnt, ltrl};
		endcase
		if (c == 3'h0 || c == 3'h2)
			s[14:1] = 14'h0000;
		if (c == 3'h1)
			s[14:8] = 7'h00;
		if (c == 3'h3)
			s[7:1] = 7'h00;
		return {edge_f({n[0], n[1]}, s[15]), s[14:1], edge_f({n[5], n[6]}, s[0])};
	endfunction : exp_y

	task automatic chk_opnd(input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("mismatch operands expected %h seen %h", e, g);
		end
	endtask : chk_opnd

	task automatic chk_alu(input logic [5:0] e, input logic [5:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("mismatch alu_ctl expected %h seen %h", e, g);
		end
	endtask : chk_alu

	task automatic chk_reg(input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("mismatch reg_rdata expected %h seen %h", e, g);
		end
	endtask : chk_reg

	task automatic finish_test;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test

	// Issue one word; the caller lowers issue, so words may run back to back
	task automatic uop(input logic [6:0] y7, input logic [3:0] op, input logic [1:0] xs);
		ey = exp_y(y7);
		ex = xs == 2'h0 ? acc1 : xs == 2'h1 ? acc2 : xs == 2'h2 ? acc3 : {cnt, ltrl};
		ea = {ot[op], op == 4'h3 || op == 4'hf};
		oq.push_back({ey, ex});
		aq.push_back(ea);
		wy <= y7;
		wa <= op;
		wx <= xs;
		issue <= 1'b1;
		@(posedge sys_clk);
	endtask : uop

	task automatic rw(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask : rw

	task automatic rr(input logic [7:0] a, input logic [31:0] e);
		addr <= a;
		reg_rd <= 1'b1;
		rq.push_back(e);
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
	endtask : rr

	// Mode and function follow the load edge; operands one edge later
	always @(posedge sys_clk)
	begin
		ld1 <= ld;
		ld2 <= ld1;
		rd1 <= reg_rd;
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_mismatch++;
			finish_test();
		end
	end

	always @(negedge sys_clk)
	begin
		if (ld1)
			chk_alu(aq.pop_front(), {mode, f3, f2, f1, f0, cin});
		if (ld2)
			chk_opnd(oq.pop_front(), {y, x});
		if (rd1)
			chk_reg(rq.pop_front(), rdata);
		else
			chk_reg(32'h0, rdata);
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		rst_n = 1'b0;
		{issue, reg_wr, reg_rd, bsel, en} = 5'h01;
		{wy, wa, wx, addr, wdata} = '0;
		{b, acc1, acc2, acc3, bas1, bas2, madr, cnt, ltrl, amp} = '0;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		// Look at the reset values away from the launching edge
		@(negedge sys_clk);
		chk_opnd(32'h0, {y, x});
		chk_alu(6'h32, {mode, f3, f2, f1, f0, cin});
		@(posedge sys_clk);
		// Every edge, source and gate code; second half uses the other base
		for (int k = 0; k < 256; k++)
		begin
			if (k == 128)
			begin
				bsel = 1'b1;
				rw(AOS_OFS_CTRL, 32'h1);
				rr(AOS_OFS_CTRL, 32'h1);
			end
			{b, acc1, acc2, acc3} <= {$random(seed), $random(seed)};
			{bas1, bas2, madr, cnt, ltrl} <= {$random(seed), $random(seed)};
			amp <= 14'($random(seed));
			@(posedge sys_clk);
			uop(7'(k), 4'($random(seed)), 2'($random(seed)));
			issue <= 1'b0;
			repeat (3) @(posedge sys_clk);
			rr(AOS_OFS_YCTL, {20'h0, wx, gt[{wy[2], wy[3], wy[4]}], wy[0], wy[1], wy[5], wy[6], 2'h0});
			rr(AOS_OFS_YOPND, {16'h0, ey});
			rr(AOS_OFS_XOPND, {16'h0, ex});
			rr(AOS_OFS_ALUCTL, {23'h0, ea[5:1], wa});
		end
		rr(8'h40, 32'h0);
		rw(8'h40, 32'hffff_ffff);
		rr(8'h40, 32'h0);
		// Clock enable low: fresh source values must not reach the operands
		en <= 1'b0;
		{b, acc1, acc2, acc3, madr} <= ~{b, acc1, acc2, acc3, madr};
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		chk_opnd({ey, ex}, {y, x});
		@(posedge sys_clk);
		en <= 1'b1;
		// Back-to-back words with every operation code
		for (int i = 0; i < 16; i++)
			uop(7'($random(seed)), 4'(i), 2'(i));
		issue <= 1'b0;
		repeat (5) @(posedge sys_clk);
		finish_test();
	end
endmodule : test_adder_operand_select
`default_nettype wire
